// ---- design/adcc_top.sv ----
// Antenna select, channel busy and converter control registers with conversion sequencing
module adcc_top
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [4:0] reg_idx_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Internal status and configuration
  input wire logic cca_carrier_in,
  input wire logic ant_criteria_pass_in,
  input wire logic receive_start_flag_in,
  input wire logic diversity_ant_sel_in,
  input wire logic diversity_conv_start_in,
  input wire logic external_conv_enable_in,
  input wire logic approximation_enable_in,
  input wire logic alternate_timing_sel_in,
  input wire logic antenna_pin_function_sel_in,
  input wire logic bus_mode_strap_in,
  // Comparator pin
  input wire logic comparator_in,
  // Antenna pins
  output logic antenna_select_output_out,
  output logic antenna_select_n_out,
  output logic antenna_pins_en_out,
  output logic diversity_enable_out,
  // Converter pins and status
  output logic [6:0] approximation_value_bits_out,
  output logic conv_input_select_out,
  output logic conversion_mode_valid_out,
  output logic conversion_active_flag_out
);
  import adcc_pkg::*;

  adcc_sar_if sar_bus ();

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic channel_busy_flag_ff;
  logic antenna_lock_flag_ff;
  logic antenna_manual_switch_ff;
  logic antenna_manual_enable_ff;
  logic converter_direction_sel_ff;
  logic conv_input_select_ff;
  logic conversion_kick_ff;
  logic [6:0] dac_value_ff;
  logic rxs_prev_ff;
  logic strap_ff;
  logic [2:0] cmp_sync_ff;
  logic cmp_stable_ff;
  logic [4:0] step_cnt_ff;
  logic [7:0] rdata_ff;
  logic ant_sel_ff;
  logic ant_en_ff;
  logic [6:0] apx_pins_ff;
  logic src_pin_ff;
  logic mode_ok_ff;
  logic ant_sel_n_ff;
  logic div_en_ff;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire wr_ctrl = reg_wr_in && (reg_idx_in == ADCC_IDX_CTRL);
  wire wr_apx = reg_wr_in && (reg_idx_in == ADCC_IDX_APPROX);
  wire rd_ctrl = reg_rd_in && (reg_idx_in == ADCC_IDX_CTRL);
  wire rd_apx = reg_rd_in && (reg_idx_in == ADCC_IDX_APPROX);
  wire rxs_rise = receive_start_flag_in && !rxs_prev_ff;

  // Judge a kick against the direction written with it, so a D/A write never converts
  wire dir_eff = wr_ctrl ? reg_wdata_in[ADCC_CTRL_DIR] : converter_direction_sel_ff;
  adcc_mode_e mode;
  assign mode = (!dir_eff && !external_conv_enable_in && !approximation_enable_in
                 && !alternate_timing_sel_in) ? ADCC_MODE_INT_A :
                (!dir_eff && !external_conv_enable_in && approximation_enable_in
                 && !alternate_timing_sel_in) ? ADCC_MODE_INT_B :
                (!dir_eff && !external_conv_enable_in && approximation_enable_in
                 && alternate_timing_sel_in) ? ADCC_MODE_INT_C :
                (!dir_eff && external_conv_enable_in && !approximation_enable_in)
                  ? ADCC_MODE_EXT :
                (dir_eff && approximation_enable_in) ? ADCC_MODE_DAC :
                ADCC_MODE_RSVD;

  wire mode_internal = (mode == ADCC_MODE_INT_A) || (mode == ADCC_MODE_INT_B) || (mode == ADCC_MODE_INT_C);
  wire mode_converts = mode_internal || (mode == ADCC_MODE_EXT);
  wire [4:0] step_len = (mode == ADCC_MODE_INT_B) ? ADCC_STEP_B :
                        (mode == ADCC_MODE_INT_C) ? ADCC_STEP_C : ADCC_STEP_A;

  wire kick_written = wr_ctrl && reg_wdata_in[ADCC_CTRL_KICK];
  wire start_req = (kick_written || (diversity_conv_start_in && !antenna_manual_enable_ff))
                   && mode_converts && !sar_bus.busy;

  wire nxt_ant_sel = antenna_manual_enable_ff ? antenna_manual_switch_ff : diversity_ant_sel_in;
  // Strap selects PCMCIA-style pinout where the antenna pins are always dedicated
  wire nxt_ant_en = strap_ff || !antenna_pin_function_sel_in;

  wire nxt_src = mode_internal ? conv_input_select_ff : 1'b0;

  wire [6:0] apx_live = (mode == ADCC_MODE_DAC) ? dac_value_ff : sar_bus.value;

  wire [7:0] ctrl_rd = {channel_busy_flag_ff, antenna_lock_flag_ff, ant_sel_ff, antenna_manual_switch_ff,
                        antenna_manual_enable_ff, converter_direction_sel_ff, conv_input_select_ff,
                        conversion_kick_ff};
  wire [7:0] apx_rd = {sar_bus.busy, apx_live};
  wire [7:0] nxt_rdata = rd_ctrl ? ctrl_rd : (rd_apx ? apx_rd : ADCC_RD_RST);

  // ------------------------------------------------------------
  // Comparator synchroniser and step divider
  // ------------------------------------------------------------
  wire cmp_agree = (cmp_sync_ff[1] == cmp_sync_ff[2]);
  wire step_hit = (step_cnt_ff == ADCC_STEP_ONE);

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cmp_sync_ff <= 3'h0;
      cmp_stable_ff <= 1'b0;
    end
    else
    begin
      cmp_sync_ff <= {cmp_sync_ff[1:0], comparator_in};
      cmp_stable_ff <= cmp_agree ? cmp_sync_ff[2] : cmp_stable_ff;
    end
  end

  // Divider restarts with each conversion so the first step gets a full settle time
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      step_cnt_ff <= ADCC_STEP_ZERO;
    end
    else if (start_req || step_hit)
    begin
      step_cnt_ff <= step_len;
    end
    else if (step_cnt_ff != ADCC_STEP_ZERO)
    begin
      step_cnt_ff <= step_cnt_ff - ADCC_STEP_ONE;
    end
  end

  assign sar_bus.start = start_req;
  assign sar_bus.step_en = step_hit && sar_bus.busy;
  assign sar_bus.cmp_high = cmp_stable_ff;

  adcc_sar u_sar (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .sar(sar_bus)
  );

  // ------------------------------------------------------------
  // Flags and control bits
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      channel_busy_flag_ff <= 1'b0;
      antenna_lock_flag_ff <= 1'b0;
      rxs_prev_ff <= 1'b0;
    end
    else
    begin
      channel_busy_flag_ff <= cca_carrier_in;
      rxs_prev_ff <= receive_start_flag_in;
      if (ant_criteria_pass_in)
      begin
        antenna_lock_flag_ff <= 1'b1;
      end
      else if (rxs_rise)
      begin
        antenna_lock_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      antenna_manual_switch_ff <= 1'b0;
      antenna_manual_enable_ff <= 1'b0;
      converter_direction_sel_ff <= 1'b0;
      conv_input_select_ff <= 1'b0;
      conversion_kick_ff <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      antenna_manual_switch_ff <= reg_wdata_in[ADCC_CTRL_SW];
      antenna_manual_enable_ff <= reg_wdata_in[ADCC_CTRL_MEN];
      converter_direction_sel_ff <= reg_wdata_in[ADCC_CTRL_DIR];
      conv_input_select_ff <= reg_wdata_in[ADCC_CTRL_SRC];
      conversion_kick_ff <= reg_wdata_in[ADCC_CTRL_KICK];
    end
  end

  // Strap is a level caught after reset release, never in the reset branch
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      strap_ff <= 1'b0;
    end
    else
    begin
      strap_ff <= bus_mode_strap_in;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      dac_value_ff <= ADCC_SAR_RST;
    end
    else if (wr_apx && converter_direction_sel_ff)
    begin
      dac_value_ff <= reg_wdata_in[ADCC_SAR_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_ff <= ADCC_RD_RST;
      ant_sel_ff <= 1'b0;
      ant_en_ff <= 1'b0;
      apx_pins_ff <= ADCC_SAR_RST;
      src_pin_ff <= 1'b0;
      mode_ok_ff <= 1'b0;
      ant_sel_n_ff <= 1'b1;
      div_en_ff <= 1'b1;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      ant_sel_ff <= nxt_ant_sel;
      ant_en_ff <= nxt_ant_en;
      apx_pins_ff <= apx_live;
      src_pin_ff <= nxt_src;
      mode_ok_ff <= (mode != ADCC_MODE_RSVD);
      ant_sel_n_ff <= ~nxt_ant_sel;
      div_en_ff <= ~antenna_manual_enable_ff;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign antenna_select_output_out = ant_sel_ff;
  assign antenna_select_n_out = ant_sel_n_ff;
  assign antenna_pins_en_out = ant_en_ff;
  assign diversity_enable_out = div_en_ff;
  assign approximation_value_bits_out = apx_pins_ff;
  assign conv_input_select_out = src_pin_ff;
  assign conversion_mode_valid_out = mode_ok_ff;
  assign conversion_active_flag_out = sar_bus.busy;
endmodule // adcc_top

// ---- inc/adcc_pkg.sv ----
// Constants and types for the antenna diversity and converter control block
package adcc_pkg;
  // Register indices in the direct register space
  localparam logic [4:0] ADCC_IDX_CTRL = 5'h1A;
  localparam logic [4:0] ADCC_IDX_APPROX = 5'h1B;
  // Control register field positions
  localparam int unsigned ADCC_CTRL_BUSY = 7;
  localparam int unsigned ADCC_CTRL_LOCK = 6;
  localparam int unsigned ADCC_CTRL_ANT = 5;
  localparam int unsigned ADCC_CTRL_SW = 4;
  localparam int unsigned ADCC_CTRL_MEN = 3;
  localparam int unsigned ADCC_CTRL_DIR = 2;
  localparam int unsigned ADCC_CTRL_SRC = 1;
  localparam int unsigned ADCC_CTRL_KICK = 0;
  // Approximation register field positions
  localparam int unsigned ADCC_APX_ACT = 7;
  localparam int unsigned ADCC_SAR_W = 7;
  localparam int unsigned ADCC_SAR_MSB = 6;
  // Reset values and first trial value
  localparam logic [6:0] ADCC_SAR_RST = 7'h00;
  localparam logic [6:0] ADCC_SAR_FIRST = 7'h40;
  localparam logic [7:0] ADCC_RD_RST = 8'h00;
  // Comparator settle cycles per step for each internal timing
  localparam logic [4:0] ADCC_STEP_A = 5'h04;
  localparam logic [4:0] ADCC_STEP_B = 5'h08;
  localparam logic [4:0] ADCC_STEP_C = 5'h10;
  localparam logic [4:0] ADCC_STEP_ONE = 5'h01;
  localparam logic [4:0] ADCC_STEP_ZERO = 5'h00;

  typedef enum logic [2:0] {
    ADCC_MODE_INT_A = 3'b000,
    ADCC_MODE_INT_B = 3'b001,
    ADCC_MODE_INT_C = 3'b010,
    ADCC_MODE_EXT = 3'b011,
    ADCC_MODE_DAC = 3'b100,
    ADCC_MODE_RSVD = 3'b111
  } adcc_mode_e;

  typedef enum logic [0:0] {
    ADCC_SAR_IDLE = 1'b0,
    ADCC_SAR_RUN = 1'b1
  } adcc_sar_state_e;
endpackage

// ---- inc/adcc_sar_if.sv ----
// Carrier between the control logic and the approximation engine
interface adcc_sar_if;
  logic start;
  logic step_en;
  logic cmp_high;
  logic busy;
  logic [6:0] value;

  modport ctrl (output start, output step_en, output cmp_high, input busy, input value);
  modport engine (input start, input step_en, input cmp_high, output busy, output value);
endinterface

// ---- design/adcc_sar.sv ----
// Successive-approximation engine: one bit resolved per step enable
module adcc_sar
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Engine side
  adcc_sar_if.engine sar
);
  import adcc_pkg::*;

  adcc_sar_state_e state_ff;
  adcc_sar_state_e nxt_state;
  logic [6:0] value_ff;
  logic [6:0] nxt_value;
  logic [2:0] bit_ff;
  logic [2:0] nxt_bit;
  logic [6:0] trial_mask;
  logic [6:0] next_mask;
  logic last_bit;

  assign trial_mask = 7'h01 << bit_ff;
  assign next_mask = trial_mask >> 1;
  assign last_bit = (bit_ff == 3'h0);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_value = value_ff;
    nxt_bit = bit_ff;
    case (state_ff)
      ADCC_SAR_IDLE:
      begin
        if (sar.start)
        begin
          nxt_state = ADCC_SAR_RUN;
          nxt_value = ADCC_SAR_FIRST;
          nxt_bit = 3'(ADCC_SAR_MSB);
        end
      end
      ADCC_SAR_RUN:
      begin
        if (sar.step_en)
        begin
          nxt_value = (sar.cmp_high ? value_ff : (value_ff & ~trial_mask)) | next_mask;
          nxt_bit = bit_ff - 3'h1;
          if (last_bit)
          begin
            nxt_state = ADCC_SAR_IDLE;
          end
        end
      end
      default:
      begin
        nxt_state = ADCC_SAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_ff <= ADCC_SAR_IDLE;
      value_ff <= ADCC_SAR_RST;
      bit_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      value_ff <= nxt_value;
      bit_ff <= nxt_bit;
    end
  end

  assign sar.busy = (state_ff == ADCC_SAR_RUN);
  assign sar.value = value_ff;
endmodule // adcc_sar

// ---- dv/adcc_top_props.sv ----
// Port-level checker for the antenna and converter control block
module adcc_top_props
  import adcc_pkg::*;
(
  // Clock, reset and register port
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [4:0] reg_idx_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Status and mode inputs
  input wire logic cca_carrier_in,
  input wire logic external_conv_enable_in,
  input wire logic approximation_enable_in,
  input wire logic alternate_timing_sel_in,
  // Outputs watched
  input wire logic antenna_select_output_out,
  input wire logic antenna_select_n_out,
  input wire logic diversity_enable_out,
  input wire logic [6:0] approximation_value_bits_out,
  input wire logic conversion_active_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [7:0] act_cnt_ff;
  logic dir_ff;
  wire wr_ctrl = reg_wr_in && (reg_idx_in == ADCC_IDX_CTRL);
  wire wr_apx = reg_wr_in && (reg_idx_in == ADCC_IDX_APPROX);
  wire rd_ctrl = reg_rd_in && (reg_idx_in == ADCC_IDX_CTRL);
  wire rd_map = reg_rd_in && (reg_idx_in == ADCC_IDX_CTRL || reg_idx_in == ADCC_IDX_APPROX);
  wire int_a = !external_conv_enable_in && !approximation_enable_in && !alternate_timing_sel_in;
  always_ff @(posedge clock_in or negedge rstn_in)
    if (!rstn_in)
      act_cnt_ff <= 8'h00;
    else
      act_cnt_ff <= conversion_active_flag_out ? act_cnt_ff + 8'h01 : 8'h00;
  // Shadow of the direction bit, which has no pin of its own
  always_ff @(posedge clock_in or negedge rstn_in)
    if (!rstn_in)
      dir_ff <= 1'b0;
    else if (wr_ctrl)
      dir_ff <= reg_wdata_in[ADCC_CTRL_DIR];
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  a_busy_follows_carrier: assert property (
    rd_ctrl && cca_carrier_in == $past(cca_carrier_in) && cca_carrier_in == $past(cca_carrier_in, 2)
    |=> reg_rdata_out[ADCC_CTRL_BUSY] == $past(cca_carrier_in)) else $error("busy bit wrong");
  a_ant_status_mirror: assert property (
    rd_ctrl |=> reg_rdata_out[ADCC_CTRL_ANT] == $past(antenna_select_output_out)) else $error("ant status wrong");
  a_ant_complement: assert property (
    antenna_select_n_out != antenna_select_output_out) else $error("ant pins not complementary");
  a_manual_switch_drive: assert property (
    wr_ctrl && reg_wdata_in[ADCC_CTRL_MEN] |-> ##2 antenna_select_output_out == $past(reg_wdata_in[ADCC_CTRL_SW], 2))
    else $error("manual switch not applied");
  a_diversity_off_manual: assert property (
    wr_ctrl |-> ##2 diversity_enable_out == !$past(reg_wdata_in[ADCC_CTRL_MEN], 2))
    else $error("diversity enable wrong");
  a_kick_starts_conv: assert property (
    wr_ctrl && reg_wdata_in[ADCC_CTRL_KICK] && !reg_wdata_in[ADCC_CTRL_DIR] && int_a && !conversion_active_flag_out
    |=> conversion_active_flag_out) else $error("kick did not start");
  a_dac_no_conv: assert property (
    wr_ctrl && reg_wdata_in[ADCC_CTRL_DIR] && approximation_enable_in && !conversion_active_flag_out
    |=> !conversion_active_flag_out) else $error("conversion in D/A mode");
  a_conv_length: assert property (
    $fell(conversion_active_flag_out) |-> act_cnt_ff inside {8'h1C, 8'h38, 8'h70})
    else $error("conversion length wrong");
  a_dac_pins_drive: assert property (
    wr_apx && dir_ff && approximation_enable_in |-> ##2 approximation_value_bits_out == $past(reg_wdata_in[6:0], 2))
    else $error("D/A pins wrong");
  a_apx_write_ignored: assert property (
    wr_apx && !dir_ff && !conversion_active_flag_out
    |-> ##2 approximation_value_bits_out == $past(approximation_value_bits_out, 2))
    else $error("approximation write leaked");
  a_read_idle_zero: assert property (
    !rd_map |=> reg_rdata_out == 8'h00) else $error("read data not zero");
  c_conv_done: cover property ($fell(conversion_active_flag_out));
  c_dac_write: cover property (wr_apx && dir_ff);
  c_manual_on: cover property (wr_ctrl && reg_wdata_in[ADCC_CTRL_MEN]);
endmodule // adcc_top_props

// ---- dv/adcc_radio_model.sv ----
// Behavioural radio: RSSI level seen through the converter comparator
module adcc_radio_model
(
  // Trial value and level
  input wire logic [6:0] trial_in,
  input wire logic [6:0] rssi_level_in,
  // Comparator result
  output logic comparator_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Comparator
  // ----------------------------------------
  // trial kept when reached
  assign comparator_out = (rssi_level_in >= trial_in);
endmodule // adcc_radio_model

// ---- dv/adcc_tb_top.sv ----
// Self-checking bench for the antenna and converter control block
module adcc_tb_top
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [4:0] reg_idx_in = 5'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic cca_carrier_in = 1'b0;
  logic ant_criteria_pass_in = 1'b0;
  logic receive_start_flag_in = 1'b0;
  logic diversity_ant_sel_in = 1'b0;
  logic diversity_conv_start_in = 1'b0;
  logic external_conv_enable_in = 1'b0;
  logic approximation_enable_in = 1'b0;
  logic alternate_timing_sel_in = 1'b0;
  logic antenna_pin_function_sel_in = 1'b1;
  logic bus_mode_strap_in = 1'b0;
  logic [6:0] rssi_level = 7'h5A;
  wire comparator_in;
  wire [7:0] reg_rdata_out;
  wire antenna_select_output_out, antenna_select_n_out, antenna_pins_en_out, diversity_enable_out;
  wire [6:0] approximation_value_bits_out;
  wire conv_input_select_out, conversion_mode_valid_out, conversion_active_flag_out;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] d;
  always #12.5 clock_in = ~clock_in;
  adcc_top dut (.clock_in, .rstn_in, .reg_idx_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
    .cca_carrier_in, .ant_criteria_pass_in, .receive_start_flag_in, .diversity_ant_sel_in,
    .diversity_conv_start_in, .external_conv_enable_in, .approximation_enable_in, .alternate_timing_sel_in,
    .antenna_pin_function_sel_in, .bus_mode_strap_in, .comparator_in, .antenna_select_output_out,
    .antenna_select_n_out, .antenna_pins_en_out, .diversity_enable_out, .approximation_value_bits_out,
    .conv_input_select_out, .conversion_mode_valid_out, .conversion_active_flag_out);
  adcc_radio_model u_radio (.trial_in(approximation_value_bits_out), .rssi_level_in(rssi_level),
    .comparator_out(comparator_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] v);
    @(negedge clock_in);
    reg_idx_in = i;
    reg_wdata_in = v;
    reg_wr_in = 1'b1;
    @(negedge clock_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [4:0] i, output logic [7:0] v);
    @(negedge clock_in);
    reg_idx_in = i;
    reg_rd_in = 1'b1;
    @(negedge clock_in);
    reg_rd_in = 1'b0;
    v = reg_rdata_out;
  endtask
  // Kick in one mode, re-kick mid-run, then check length, routing and result
  task automatic conv(input logic [2:0] m, input int len, input logic [7:0] wb, input logic sx, input logic [7:0] res);
    int n;
    logic [7:0] v;
    n = 0;
    {external_conv_enable_in, approximation_enable_in, alternate_timing_sel_in} = m;
    wr(ADCC_IDX_CTRL, wb);
    // The cycle right after the kick edge is already active
    n = (conversion_active_flag_out === 1'b1) ? 1 : 0;
    repeat (200)
    begin
      @(negedge clock_in);
      reg_wr_in = (n == 5);
      if (n == 2)
        chk(conv_input_select_out, sx);
      if (conversion_active_flag_out === 1'b1)
        n++;
      else if (n > 0)
        break;
    end
    chk(8'(n), 8'(len));
    chk(conversion_mode_valid_out, len != 0);
    rd(ADCC_IDX_APPROX, v);
    if (res != 8'hFF)
      chk(v, res);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (2) @(negedge clock_in);
    rstn_in = 1'b1;
    rd(ADCC_IDX_CTRL, d);
    chk(d, ADCC_RD_RST);
    chk({antenna_select_n_out, diversity_enable_out}, 2'b11);
    cca_carrier_in = 1'b1;
    rd(ADCC_IDX_CTRL, d);
    chk(d & 8'h80, 8'h80);
    cca_carrier_in = 1'b0;
    wr(ADCC_IDX_CTRL, 8'h80);
    rd(ADCC_IDX_CTRL, d);
    chk(d & 8'h80, 8'h00);
    ant_criteria_pass_in = 1'b1;
    @(negedge clock_in);
    ant_criteria_pass_in = 1'b0;
    rd(ADCC_IDX_CTRL, d);
    chk(d & 8'h40, 8'h40);
    receive_start_flag_in = 1'b1;
    rd(ADCC_IDX_CTRL, d);
    chk(d & 8'h40, 8'h00);
    wr(ADCC_IDX_CTRL, 8'h18);
    rd(ADCC_IDX_CTRL, d);
    chk(d & 8'h20, 8'h20);
    chk({antenna_select_output_out, antenna_select_n_out, diversity_enable_out}, 3'b100);
    diversity_ant_sel_in = 1'b1;
    wr(ADCC_IDX_CTRL, 8'h08);
    @(negedge clock_in);
    chk(antenna_select_output_out, 1'b0);
    diversity_ant_sel_in = 1'b0;
    wr(ADCC_IDX_CTRL, 8'h10);
    @(negedge clock_in);
    chk(antenna_select_output_out, 1'b0);
    diversity_ant_sel_in = 1'b1;
    rd(ADCC_IDX_CTRL, d);
    chk(d & 8'h20, 8'h20);
    for (int k = 0; k < 4; k++)
    begin
      {antenna_pin_function_sel_in, bus_mode_strap_in} = 2'(k);
      repeat (2) @(negedge clock_in);
      chk(antenna_pins_en_out, bus_mode_strap_in | !antenna_pin_function_sel_in);
    end
    // Receive start stays high: kicks must still convert
    conv(3'b000, 28, 8'h03, 1'b1, 8'hFF);
    conv(3'b100, 28, 8'h03, 1'b0, 8'hFF);
    conv(3'b010, 56, 8'h01, 1'b0, 8'h5A);
    conv(3'b011, 112, 8'h03, 1'b1, 8'h5A);
    conv(3'b001, 0, 8'h03, 1'b0, 8'hFF);
    conv(3'b110, 0, 8'h03, 1'b0, 8'hFF);
    // Diversity request converts while manual enable is off
    {external_conv_enable_in, approximation_enable_in, alternate_timing_sel_in} = 3'b010;
    diversity_conv_start_in = 1'b1;
    @(negedge clock_in);
    diversity_conv_start_in = 1'b0;
    chk(conversion_active_flag_out, 1'b1);
    repeat (60) @(negedge clock_in);
    chk(conversion_active_flag_out, 1'b0);
    {external_conv_enable_in, approximation_enable_in, alternate_timing_sel_in} = 3'b010;
    wr(ADCC_IDX_CTRL, 8'h05);
    @(negedge clock_in);
    chk(conversion_active_flag_out, 1'b0);
    wr(ADCC_IDX_APPROX, 8'h33);
    repeat (2) @(negedge clock_in);
    chk(approximation_value_bits_out, 7'h33);
    rd(ADCC_IDX_APPROX, d);
    chk(d, 8'h33);
    wr(ADCC_IDX_CTRL, 8'h00);
    wr(ADCC_IDX_APPROX, 8'h55);
    repeat (2) @(negedge clock_in);
    chk(approximation_value_bits_out, 7'h5A);
    rd(ADCC_IDX_APPROX, d);
    chk(d, 8'h5A);
    rd(5'h05, d);
    chk(d, 8'h00);
    summarize();
  end
endmodule // adcc_tb_top

bind adcc_top adcc_top_props u_props (.clock_in, .rstn_in, .reg_idx_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
  .reg_rdata_out, .cca_carrier_in, .external_conv_enable_in, .approximation_enable_in, .alternate_timing_sel_in,
  .antenna_select_output_out, .antenna_select_n_out, .diversity_enable_out, .approximation_value_bits_out,
  .conversion_active_flag_out);
